// [dv/tcr_host_model.sv]
`timescale 1ns/10ps
module tcr_host_model
(
	// Clock and answer
	input  wire logic        clk_in,
	input  wire logic        pready_in,
	input  wire logic        pslverr_in,
	input  wire logic [31:0] prdata_in,
	// Request
	output logic             psel_out,
	output logic             penable_out,
	output logic             pwrite_out,
	output logic      [11:0] paddr_out,
	output logic      [31:0] pwdata_out
);
	initial
	begin
		{psel_out, penable_out, pwrite_out, paddr_out, pwdata_out} = '0;
	end
	// Psel stays up so a following setup needs no extra edge
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		psel_out <= 1'b1;
		pwrite_out <= w;
		paddr_out <= a;
		pwdata_out <= d;
		@(posedge clk_in);
		penable_out <= 1'b1;
		do
			@(posedge clk_in);
		while (pready_in !== 1'b1);
		r = prdata_in;
		e = pslverr_in;
		penable_out <= 1'b0;
	endtask
	task automatic idle();
		psel_out <= 1'b0;
		@(posedge clk_in);
	endtask
endmodule

// [dv/tcr_regs_asserts.sv]
`timescale 1ns/10ps
module tcr_regs_asserts
(
	// Clock, reset, sync
	input wire logic        clk_in,
	input wire logic        rst_in,
	input wire logic        ce_in,
	input wire logic        sync_in,
	// APB
	input wire logic        psel_in,
	input wire logic        penable_in,
	input wire logic        pwrite_in,
	input wire logic [11:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic [31:0] prdata_out,
	input wire logic        pready_out,
	// Settings
	input wire logic        chan_a_fir2_bank_pick_out,
	input wire logic        chan_b_fir2_bank_pick_out,
	input wire logic        chain_master_on_out,
	input tcr_pkg::tcr_comb_t gain_detector_comb_choice_out,
	input wire logic [4:0]  extra_gain_align_lag_out,
	input wire logic [5:0]  gain_step_lag_out
);
	// A write with the enable low is dropped, so it is not a write here
	wire wr = psel_in && penable_in && pwrite_in && pready_out && ce_in;
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);
	AST_CHA: assert property (wr && paddr_in == 12'h3DC |=>
		chan_a_fir2_bank_pick_out == $past(pwdata_in[0])) else $error("bank a");
	AST_CHB: assert property (wr && paddr_in == 12'h3DC |=>
		chan_b_fir2_bank_pick_out == $past(pwdata_in[1])) else $error("bank b");
	AST_CHAIN: assert property (wr && paddr_in == 12'h3E0 |=>
		chain_master_on_out == $past(pwdata_in[1])) else $error("chain");
	AST_COMB: assert property (wr && paddr_in == 12'h3E4 |=>
		gain_detector_comb_choice_out == $past(pwdata_in[1:0]))
		else $error("comb");
	AST_LAG: assert property (gain_step_lag_out ==
		6'h04 + extra_gain_align_lag_out) else $error("lag");
	// Reset must win even though everything else is disabled by it
	AST_RST: assert property (disable iff (1'b0) rst_in |=>
		prdata_out == 32'h0 && !chain_master_on_out && !chan_a_fir2_bank_pick_out
		&& extra_gain_align_lag_out == 5'h00) else $error("reset");
	AST_SYNC: assert property (sync_in && !wr |=> $stable({
		chan_a_fir2_bank_pick_out, chan_b_fir2_bank_pick_out,
		chain_master_on_out, extra_gain_align_lag_out})) else $error("sync");
	AST_HI: assert property (prdata_out[31:8] == 24'h0)
		else $error("upper bits");
endmodule

bind tcr_regs tcr_regs_asserts u_tcr_regs_asserts (.*);

// [dv/tcr_regs_tb.sv]
`timescale 1ns/10ps
module tcr_regs_tb;
	logic clk_in, rst_in, ce_in, sync_in, packed_in, er;
	logic word_start_in, pair_start_in, sample_start_in;
	logic [4:0] tap_in;
	logic [31:0] rd;
	wire psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
	wire serial_frame_sync_out, chain_master_on_out;
	wire chan_a_fir2_bank_pick_out, chan_b_fir2_bank_pick_out;
	wire [11:0] paddr_in;
	wire [31:0] pwdata_in, prdata_out;
	tcr_pkg::tcr_comb_t gain_detector_comb_choice_out;
	wire [4:0] extra_gain_align_lag_out;
	wire [5:0] gain_step_lag_out;
	wire [15:0] cha_coef_out, chb_coef_out;
	int mismatches, checks, cyc;
	typedef struct {logic [11:0] a; logic [7:0] w, r; logic [15:0] o;} tcr_row_t;
	// Rows build on each other: outputs are cumulative
	tcr_row_t rows [7] = '{'{12'h3DC, 8'h01, 8'h01, 16'h8004},
		'{12'h3DC, 8'hFA, 8'h02, 16'h4004}, '{12'h3E0, 8'hFE, 8'h02, 16'h6004},
		'{12'h3E4, 8'h05, 8'h05, 16'h6845}, '{12'h3E4, 8'h7E, 8'h7E, 16'h77E3},
		'{12'h3E4, 8'h80, 8'h00, 16'h6004}, '{12'h000, 8'hA5, 8'hA5, 16'h6004}};
	logic [19:0] cw [6] = '{20'h3DC00, 20'h2D834, 20'h2DC12, 20'h3DC04,
		20'h2D878, 20'h2DC56};
	wire [15:0] obs = {chan_a_fir2_bank_pick_out, chan_b_fir2_bank_pick_out,
		chain_master_on_out, gain_detector_comb_choice_out,
		extra_gain_align_lag_out, gain_step_lag_out};
	tcr_regs u_tcr_regs (.*);
	tcr_host_model host (.clk_in(clk_in), .pready_in(pready_out),
		.pslverr_in(pslverr_out), .prdata_in(prdata_out), .psel_out(psel_in),
		.penable_out(penable_in), .pwrite_out(pwrite_in),
		.paddr_out(paddr_in), .pwdata_out(pwdata_in));
	initial
	begin
		clk_in = 1'b0;
		forever #10 clk_in = ~clk_in;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("FAIL t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic pulse(input logic p, input logic [2:0] s, input logic e);
		packed_in <= p;
		{word_start_in, pair_start_in, sample_start_in} <= s;
		@(posedge clk_in);
		{word_start_in, pair_start_in, sample_start_in} <= 3'b000;
		#1 chk(serial_frame_sync_out, e);
		@(posedge clk_in);
	endtask
	always @(posedge clk_in)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			mismatches++;
			complete_run();
		end
	end
	initial
	begin
		{rst_in, sync_in, packed_in, tap_in} = 8'h80;
		ce_in = 1'b1;
		{word_start_in, pair_start_in, sample_start_in} = 3'b000;
		repeat (5) @(posedge clk_in);
		rst_in <= 1'b0;
		// The row before last puts the lag back to zero for the companion part
		foreach (rows[i])
		begin
			host.xfer(1'b1, rows[i].a, {24'h0, rows[i].w}, rd, er);
			host.xfer(1'b0, rows[i].a, 32'h0, rd, er);
			chk(rd, {24'h0, rows[i].r});
			chk(obs, rows[i].o);
			$display("row %0d done", i);
		end
		// Enable low freezes state: a write in that time must not land
		ce_in <= 1'b0;
		host.xfer(1'b1, 12'h3E0, 32'h0, rd, er);
		host.idle();
		ce_in <= 1'b1;
		chk(obs, 16'h6004);
		$display("clock enable done");
		host.xfer(1'b0, 12'h004, 32'h0, rd, er);
		chk({er, rd[30:0]}, 32'h80000000);
		host.idle();
		sync_in <= 1'b1;
		@(posedge clk_in);
		sync_in <= 1'b0;
		@(posedge clk_in);
		chk(obs, 16'h6004);
		$display("unmapped and sync done");
		pulse(1'b1, 3'b100, 1'b1);
		pulse(1'b1, 3'b010, 1'b0);
		pulse(1'b0, 3'b010, 1'b1);
		pulse(1'b0, 3'b001, 1'b0);
		host.xfer(1'b1, 12'h3E0, 32'h1, rd, er);
		host.idle();
		pulse(1'b1, 3'b001, 1'b1);
		pulse(1'b0, 3'b100, 1'b0);
		$display("frame sync done");
		foreach (cw[j])
			host.xfer(1'b1, cw[j][19:8], {24'h0, cw[j][7:0]}, rd, er);
		host.xfer(1'b0, 12'h2D8, 32'h0, rd, er);
		chk(rd, 32'h78);
		host.xfer(1'b1, 12'h3DC, 32'h6, rd, er);
		host.idle();
		repeat (2) @(posedge clk_in);
		chk(cha_coef_out, 16'h1234);
		chk(chb_coef_out, 16'h5678);
		$display("coefficients done");
		rst_in <= 1'b1;
		repeat (5) @(posedge clk_in);
		rst_in <= 1'b0;
		host.xfer(1'b0, 12'h3DC, 32'h0, rd, er);
		chk(rd, 32'h0);
		chk(obs, 16'h0004);
		host.xfer(1'b0, 12'h3E0, 32'h0, rd, er);
		chk(rd, 32'h0);
		$display("reset done");
		complete_run();
	end
endmodule

// [logic/tcr_coef_if.sv]
`timescale 1ns/10ps
interface tcr_coef_if;
	logic                 wr_en;
	logic                 bank;
	logic [5:0]           byte_addr;
	logic [7:0]           wdata;
	logic [7:0]           rdata;

	modport owner
	(
		output wr_en,
		output bank,
		output byte_addr,
		output wdata,
		input  rdata
	);
	modport store
	(
		input  wr_en,
		input  bank,
		input  byte_addr,
		input  wdata,
		output rdata
	);
endinterface

// [logic/tcr_coef_mem.sv]
`timescale 1ns/10ps
module tcr_coef_mem
(
	// Clocking
	input  wire logic clk_in,
	input  wire logic ce_in,
	// Host window
	tcr_coef_if.store host,
	// Filter side reads
	input  wire logic [4:0]  tap_in,
	input  wire logic        cha_bank_in,
	input  wire logic        chb_bank_in,
	output logic      [15:0] cha_coef_out,
	output logic      [15:0] chb_coef_out
);
	// Bytes kept separately so the host can write one half of a word
	logic [7:0] mem_a_lo [tcr_pkg::COEF_WORDS];
	logic [7:0] mem_a_hi [tcr_pkg::COEF_WORDS];
	logic [7:0] mem_b_lo [tcr_pkg::COEF_WORDS];
	logic [7:0] mem_b_hi [tcr_pkg::COEF_WORDS];
	logic [4:0] word;
	logic       hi_byte;

	assign word    = host.byte_addr[5:1];
	assign hi_byte = host.byte_addr[0];

	always_ff @(posedge clk_in)
	begin
		if (ce_in && host.wr_en)
		begin
			if (!host.bank && !hi_byte)
				mem_a_lo[word] <= host.wdata;
			if (!host.bank && hi_byte)
				mem_a_hi[word] <= host.wdata;
			if (host.bank && !hi_byte)
				mem_b_lo[word] <= host.wdata;
			if (host.bank && hi_byte)
				mem_b_hi[word] <= host.wdata;
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (ce_in)
		begin
			case ({host.bank, hi_byte})
				2'h0:    host.rdata <= mem_a_lo[word];
				2'h1:    host.rdata <= mem_a_hi[word];
				2'h2:    host.rdata <= mem_b_lo[word];
				default: host.rdata <= mem_b_hi[word];
			endcase
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (ce_in)
		begin
			cha_coef_out <= cha_bank_in
				? {mem_b_hi[tap_in], mem_b_lo[tap_in]}
				: {mem_a_hi[tap_in], mem_a_lo[tap_in]};
			chb_coef_out <= chb_bank_in
				? {mem_b_hi[tap_in], mem_b_lo[tap_in]}
				: {mem_a_hi[tap_in], mem_a_lo[tap_in]};
		end
	end
endmodule

// [logic/tcr_pkg.sv]
package tcr_pkg;

	// Register indices; the byte address on APB is four times the index
	localparam logic [7:0] IDX_DECIM      = 8'h00;
	localparam logic [7:0] IDX_F2_CTRL    = 8'hF7;
	localparam logic [7:0] IDX_SER_CTRL2  = 8'hF8;
	localparam logic [7:0] IDX_AGC_CTRL2  = 8'hF9;
	localparam logic [7:0] IDX_F2_COEF_LO = 8'hB6;
	localparam logic [7:0] IDX_F2_COEF_HI = 8'hF5;

	// Field positions
	localparam int CHA_BANK_BIT    = 0;
	localparam int CHB_BANK_BIT    = 1;
	localparam int WIN_BANK_BIT    = 2;
	localparam int FS_PLACE_BIT    = 0;
	localparam int CHAIN_BIT       = 1;
	localparam int COMB_LSB        = 0;
	localparam int LAG_LSB         = 2;
	localparam int COMB_W          = 2;
	localparam int LAG_W           = 5;

	// Reset values
	localparam logic [7:0] DECIM_RST     = 8'h00;
	localparam logic       BANK_RST      = 1'h0;
	localparam logic       FS_PLACE_RST  = 1'h0;
	localparam logic       CHAIN_RST     = 1'h0;
	localparam logic [1:0] COMB_RST      = 2'h0;
	localparam logic [4:0] LAG_RST       = 5'h0;

	// Fixed base delay of the gain compensation step, sample clocks
	localparam logic [5:0] LAG_BASE      = 6'h04;

	// Coefficient store: 32 words of 16 bits, 64 byte addresses
	localparam int COEF_WORDS = 32;
	localparam int COEF_AW    = 6;

	typedef enum logic [1:0]
	{
		tcr_comb_none,
		tcr_comb_one_tap,
		tcr_comb_four_tap,
		tcr_comb_rsvd
	} tcr_comb_t;

endpackage

// [logic/tcr_regs.sv]
// Overview of operation
// - Bit 0 at index 247 picks memory A (0) or B (1) for channel A FIR2.
// - Bit 1 at index 247 picks memory A (0) or B (1) for channel B FIR2.
// - Bit 2 at index 247 picks the memory the host coefficient window hits.
// - Placement 0 pulses frame sync per packed word or per I/Q pair.
// - Placement 1 pulses frame sync once per output sample period.
// - Bit 1 at index 248 makes the serial port a daisy chain master.
// - Bits 1:0 at index 249 choose the gain detector comb: none, 1 or 4 tap.
// - Bits 6:2 at index 249 add that many clocks to a base lag of 4.
// - Master clear loads every field with its zero default.
// - The sync input never alters any configuration field.
// - Coefficient indices 182 to 245 go to memory B when the page bit is 1.
// - FIR2 holds 32 signed 16-bit words, low byte at the lower index.
`timescale 1ns/10ps
module tcr_regs
(
	// Clock, reset, enable
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	input  wire logic        ce_in,
	// Sync input, deliberately without effect on configuration
	input  wire logic        sync_in,
	// APB slave
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [11:0] paddr_in,
	input  wire logic [31:0] pwdata_in,
	output logic      [31:0] prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	// Serial port timing from the datapath
	input  wire logic        packed_in,
	input  wire logic        word_start_in,
	input  wire logic        pair_start_in,
	input  wire logic        sample_start_in,
	output logic             serial_frame_sync_out,
	output logic             chain_master_on_out,
	// Gain loop settings
	output tcr_pkg::tcr_comb_t gain_detector_comb_choice_out,
	output logic      [4:0]  extra_gain_align_lag_out,
	output logic      [5:0]  gain_step_lag_out,
	// FIR2 coefficient feed
	input  wire logic [4:0]  tap_in,
	output logic             chan_a_fir2_bank_pick_out,
	output logic             chan_b_fir2_bank_pick_out,
	output logic      [15:0] cha_coef_out,
	output logic      [15:0] chb_coef_out
);
	logic [7:0] decim_r;
	logic       cha_bank_r;
	logic       chb_bank_r;
	logic       win_bank_r;
	logic       fs_place_r;
	logic       chain_r;
	logic [1:0] comb_r;
	logic [4:0] lag_r;
	logic       rd_pend_r;
	logic [7:0] idx;
	logic       aligned;
	logic       is_coef;
	logic       is_known;
	logic       access;
	logic       wr_go;
	logic [7:0] wbyte;
	logic [7:0] reg_rd;
	logic [5:0] coef_off;

	tcr_coef_if coef ();

	function automatic logic in_coef(input logic [7:0] i);
		return i >= tcr_pkg::IDX_F2_COEF_LO && i <= tcr_pkg::IDX_F2_COEF_HI;
	endfunction

	assign idx      = paddr_in[9:2];
	assign aligned  = paddr_in[1:0] == 2'h0 && paddr_in[11:10] == 2'h0;
	assign is_coef  = aligned && in_coef(idx);
	assign is_known = aligned && (in_coef(idx)
		|| idx == tcr_pkg::IDX_DECIM
		|| idx == tcr_pkg::IDX_F2_CTRL
		|| idx == tcr_pkg::IDX_SER_CTRL2
		|| idx == tcr_pkg::IDX_AGC_CTRL2);
	assign access   = psel_in && penable_in && ce_in;
	assign wbyte    = pwdata_in[7:0];
	assign coef_off = 6'(idx - tcr_pkg::IDX_F2_COEF_LO);

	// Coefficient reads need one extra cycle for the registered memory
	assign pready_out  = !(is_coef && !pwrite_in) || rd_pend_r;
	assign pslverr_out = psel_in && penable_in && !is_known;
	assign wr_go       = access && pwrite_in && pready_out && is_known;

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			rd_pend_r <= 1'b0;
		else if (ce_in)
			rd_pend_r <= psel_in && penable_in && is_coef && !pwrite_in
				&& !rd_pend_r;
	end

	// Reset and writes only; sync_in is intentionally not a term here
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			decim_r    <= tcr_pkg::DECIM_RST;
			cha_bank_r <= tcr_pkg::BANK_RST;
			chb_bank_r <= tcr_pkg::BANK_RST;
			win_bank_r <= tcr_pkg::BANK_RST;
			fs_place_r <= tcr_pkg::FS_PLACE_RST;
			chain_r    <= tcr_pkg::CHAIN_RST;
			comb_r     <= tcr_pkg::COMB_RST;
			lag_r      <= tcr_pkg::LAG_RST;
		end
		else if (wr_go)
		begin
			case (idx)
				tcr_pkg::IDX_DECIM:
					decim_r <= wbyte;
				tcr_pkg::IDX_F2_CTRL:
				begin
					cha_bank_r <= wbyte[tcr_pkg::CHA_BANK_BIT];
					chb_bank_r <= wbyte[tcr_pkg::CHB_BANK_BIT];
					win_bank_r <= wbyte[tcr_pkg::WIN_BANK_BIT];
				end
				tcr_pkg::IDX_SER_CTRL2:
				begin
					fs_place_r <= wbyte[tcr_pkg::FS_PLACE_BIT];
					chain_r    <= wbyte[tcr_pkg::CHAIN_BIT];
				end
				tcr_pkg::IDX_AGC_CTRL2:
				begin
					comb_r <= wbyte[tcr_pkg::COMB_LSB +: tcr_pkg::COMB_W];
					lag_r  <= wbyte[tcr_pkg::LAG_LSB +: tcr_pkg::LAG_W];
				end
				default:
					decim_r <= decim_r;
			endcase
		end
	end

	always_comb
	begin
		reg_rd = 8'h00;
		case (idx)
			tcr_pkg::IDX_DECIM:
				reg_rd = decim_r;
			tcr_pkg::IDX_F2_CTRL:
				reg_rd = {5'h00, win_bank_r, chb_bank_r, cha_bank_r};
			tcr_pkg::IDX_SER_CTRL2:
				reg_rd = {6'h00, chain_r, fs_place_r};
			tcr_pkg::IDX_AGC_CTRL2:
				reg_rd = {1'h0, lag_r, comb_r};
			default:
				reg_rd = 8'h00;
		endcase
	end

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			prdata_out <= 32'h0000_0000;
		else if (ce_in && psel_in && !penable_in && !pwrite_in && !is_coef)
			prdata_out <= {24'h00_0000, is_known ? reg_rd : 8'h00};
		// Loaded in the wait state so the byte stands when pready rises
		else if (ce_in && psel_in && penable_in && is_coef && !pwrite_in
			&& !rd_pend_r)
			prdata_out <= {24'h00_0000, coef.rdata};
	end

	assign coef.wr_en     = wr_go && is_coef;
	assign coef.bank      = win_bank_r;
	assign coef.byte_addr = coef_off;
	assign coef.wdata     = wbyte;

	tcr_coef_mem u_mem
	(
		.clk_in       (clk_in),
		.ce_in        (ce_in),
		.host         (coef.store),
		.tap_in       (tap_in),
		.cha_bank_in  (cha_bank_r),
		.chb_bank_in  (chb_bank_r),
		.cha_coef_out (cha_coef_out),
		.chb_coef_out (chb_coef_out)
	);

	// Frame sync registered so it lines up one clock after the strobes
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			serial_frame_sync_out <= 1'b0;
		else if (ce_in)
		begin
			if (fs_place_r)
				serial_frame_sync_out <= sample_start_in;
			else if (packed_in)
				serial_frame_sync_out <= word_start_in;
			else
				serial_frame_sync_out <= pair_start_in;
		end
	end

	assign chain_master_on_out           = chain_r;
	assign gain_detector_comb_choice_out = tcr_pkg::tcr_comb_t'(comb_r);
	assign extra_gain_align_lag_out      = lag_r;
	assign gain_step_lag_out = tcr_pkg::LAG_BASE + {1'b0, lag_r};
	assign chan_a_fir2_bank_pick_out     = cha_bank_r;
	assign chan_b_fir2_bank_pick_out     = chb_bank_r;
endmodule
